// ---- src/crs_sequencer.sv ----
// clock control, rc trim and reset sequence manager with an axi4-lite slave
// assumes a 40 MHz oscillator clock on aclk; the reset pin is external and
// open drain, the supply and watchdog sources arrive asynchronously
`timescale 1ns/10ps
`default_nettype none
`include "crs_consts.svh"

// Summary of operation
// - clock control resets zero, upper bits reserved
// - clock-out enable bit drives clock pin once the core is out of reset
// - slow bit divides cpu clock by 32
// - trim register resets to all ones
// - trim zero fastest, all ones slowest
// - all sources pull pin; low during delay
// - fetch start address from top vector
// - phases: active, delay, vector fetch
// - delay 256 for rc/ext, 4096 crystal
// - vector fetch lasts two cycles
// - pll adds startup delay when enabled
// - external low pulse sampled through a two-flop synchroniser on aclk
// - reset pin open drain, never driven high
// - crystal keeps running, no restart added
// - watchdog underflow pulls pin for minimum width
// - supply reset holds pin low
// - illegal opcode also starts reset sequence
// - clock source fixed by configuration input
// - watchdog flag cleared by zero or supply
// - supply flag cleared on read only
module crs_sequencer #(
	parameter int DELAY_LONG  = `CRS_DELAY_LONG,
	parameter int DELAY_SHORT = `CRS_DELAY_SHORT,
	parameter int PLL_STARTUP = `CRS_PLL_STARTUP,
	parameter int WDG_PULSE   = `CRS_WDG_PULSE
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire crs_pkg::crs_osc_t osc_select,
	input  wire logic        pll_enable,
	input  wire logic        reset_pin_in,
	output var  logic        reset_pin_out,
	output var  logic        reset_pin_oe_n,
	input  wire logic        supply_monitor_reset,
	input  wire logic        watchdog_underflow,
	input  wire logic        illegal_opcode,
	output var  logic        core_reset_n,
	output var  logic        vector_fetch,
	output var  logic [15:0] vector_addr,
	output var  logic        cpu_clk_en,
	output var  logic        clock_out_enable,
	output var  logic [7:0]  trim_value
);
	import crs_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic        aw_ok;
		logic [3:0]  aw_addr;
		logic        w_ok;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [7:0]  main_clock_control;
		logic [7:0]  rc_trim;
		logic        watchdog_reset_flag;
		logic        supply_reset_flag;
		crs_phase_t  phase;
		logic [12:0] cnt;
		logic [7:0]  wdg_cnt;
		logic        pin_drive;
		logic [1:0]  drv_hist;
		logic        core_rst_n;
		logic        fetch;
		logic [15:0] vaddr;
		logic        clkout;
	} crs_st_t;
	crs_st_t st_q, st_d;

	logic     pin_sync;
	logic     supply_sync;
	logic     wdg_sync;
	logic     wdg_prev_q;
	logic     div_en;
	crs_src_t src;

	function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		merge_byte = strb[0] ? d[7:0] : old;
	endfunction : merge_byte

	function automatic logic [12:0] delay_len(input crs_osc_t osc);
		delay_len = (osc == CRS_OSC_XTAL) ? 13'(DELAY_LONG) : 13'(DELAY_SHORT);
	endfunction : delay_len

	// ------------------------------------------------------------
	// input synchronisers and slow divider
	// ------------------------------------------------------------
	crs_sync u_pin_sync (.aclk(aclk), .aresetn(aresetn), .din(reset_pin_in),
		.dout(pin_sync));
	crs_sync u_sup_sync (.aclk(aclk), .aresetn(aresetn), .din(!supply_monitor_reset),
		.dout(supply_sync));
	crs_sync u_wdg_sync (.aclk(aclk), .aresetn(aresetn), .din(!watchdog_underflow),
		.dout(wdg_sync));
	crs_clkdiv #(.DIV(`CRS_SLOW_DIV)) u_div (.aclk(aclk), .aresetn(aresetn),
		.slow(st_q.main_clock_control[`CRS_BIT_SLOW]), .cpu_en(div_en));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdg_prev_q <= 1'b1;
		end else begin
			wdg_prev_q <= wdg_sync;
		end
	end

	// pin level sampled after synchronising; a pulse shorter than the
	// minimum width may be missed; own drive stays masked until the syncs flush
	always_comb begin
		src.ext_low  = !pin_sync && !st_q.pin_drive && st_q.drv_hist == 2'b00;
		src.supply   = !supply_sync;
		src.watchdog = wdg_prev_q && !wdg_sync;
		src.illegal  = illegal_opcode && st_q.phase == CRS_RUN;
	end

	// ------------------------------------------------------------
	// register bus and sequencer
	// ------------------------------------------------------------
	always_comb begin
		logic do_wr;
		logic do_rd;
		logic any_src;
		do_wr = 1'b0;
		do_rd = 1'b0;
		any_src = 1'b0;
		st_d = st_q;

		if (s_axi_awvalid && !st_q.aw_ok) begin
			st_d.aw_ok = 1'b1;
			st_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_q.w_ok) begin
			st_d.w_ok = 1'b1;
			st_d.w_data = s_axi_wdata;
			st_d.w_strb = s_axi_wstrb;
		end
		if (st_q.bvalid && s_axi_bready) begin
			st_d.bvalid = 1'b0;
		end
		if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end

		do_wr = st_q.aw_ok && st_q.w_ok && !st_q.bvalid;
		if (do_wr) begin
			st_d.aw_ok = 1'b0;
			st_d.w_ok = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = `CRS_RESP_OKAY;
			unique case (st_q.aw_addr)
				`CRS_ADDR_CLK_CTRL: begin
					st_d.main_clock_control = merge_byte(st_q.main_clock_control,
						st_q.w_data, st_q.w_strb) & `CRS_CLK_CTRL_MASK;
				end
				`CRS_ADDR_TRIM: begin
					st_d.rc_trim = merge_byte(st_q.rc_trim, st_q.w_data, st_q.w_strb);
				end
				`CRS_ADDR_FLAGS: begin
					if (st_q.w_strb[0] && !st_q.w_data[`CRS_BIT_WATCHDOG_RESET_FLAG]) begin
						st_d.watchdog_reset_flag = 1'b0;
					end
				end
				`CRS_ADDR_STATUS: begin
				end
				default: begin
					st_d.bresp = `CRS_RESP_SLVERR;
				end
			endcase
		end

		do_rd = s_axi_arvalid && !st_q.rvalid;
		if (do_rd) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = `CRS_RESP_OKAY;
			st_d.rdata = 32'h0000_0000;
			unique case (s_axi_araddr)
				`CRS_ADDR_CLK_CTRL: st_d.rdata[7:0] = st_q.main_clock_control;
				`CRS_ADDR_TRIM:     st_d.rdata[7:0] = st_q.rc_trim;
				`CRS_ADDR_FLAGS: begin
					st_d.rdata[`CRS_BIT_WATCHDOG_RESET_FLAG] = st_q.watchdog_reset_flag;
					st_d.rdata[`CRS_BIT_SUPPLY_RESET_FLAG] = st_q.supply_reset_flag;
					st_d.supply_reset_flag = 1'b0;
				end
				`CRS_ADDR_STATUS: begin
					st_d.rdata[2:0] = 3'(st_q.phase);
					st_d.rdata[3] = st_q.core_rst_n;
				end
				default: begin
					st_d.rresp = `CRS_RESP_SLVERR;
				end
			endcase
		end

		// hardware sets win over software clears
		if (src.watchdog) begin
			st_d.watchdog_reset_flag = 1'b1;
		end
		if (src.supply) begin
			st_d.supply_reset_flag = 1'b1;
			st_d.watchdog_reset_flag = 1'b0;
		end

		// watchdog output pulse has a guaranteed minimum width
		if (src.watchdog) begin
			st_d.wdg_cnt = 8'(WDG_PULSE);
		end else if (st_q.wdg_cnt != 8'h00) begin
			st_d.wdg_cnt = st_q.wdg_cnt - 8'h01;
		end

		any_src = src.ext_low || src.supply || src.watchdog || src.illegal
			|| st_q.wdg_cnt != 8'h00;

		st_d.fetch = 1'b0;
		if (any_src) begin
			// every source re-enters the active phase and resets the count
			st_d.phase = CRS_ACTIVE;
			st_d.cnt = 13'h0000;
			st_d.core_rst_n = 1'b0;
			st_d.main_clock_control = `CRS_CLK_CTRL_RESET;
			st_d.rc_trim = `CRS_TRIM_RESET;
		end else begin
			unique case (st_q.phase)
				CRS_ACTIVE: begin
					st_d.cnt = 13'h0000;
					// oscillator is never stopped, so no restart wait here
					st_d.phase = pll_enable ? CRS_PLL_WAIT : CRS_DELAY;
				end
				CRS_PLL_WAIT: begin
					st_d.cnt = st_q.cnt + 13'h0001;
					if (st_q.cnt == 13'(PLL_STARTUP - 1)) begin
						st_d.cnt = 13'h0000;
						st_d.phase = CRS_DELAY;
					end
				end
				CRS_DELAY: begin
					if (div_en) begin
						st_d.cnt = st_q.cnt + 13'h0001;
						if (st_q.cnt == delay_len(osc_select) - 13'h0001) begin
							st_d.cnt = 13'h0000;
							st_d.phase = CRS_FETCH;
						end
					end
				end
				CRS_FETCH: begin
					st_d.fetch = 1'b1;
					st_d.vaddr = st_q.cnt[0] ? 16'hffff : 16'hfffe;
					st_d.cnt = st_q.cnt + 13'h0001;
					if (st_q.cnt == 13'(`CRS_FETCH_CYCLES - 1)) begin
						st_d.cnt = 13'h0000;
						st_d.phase = CRS_RUN;
						st_d.core_rst_n = 1'b1;
					end
				end
				CRS_RUN: begin
				end
			endcase
		end

		// pin pulled low in active, pll wait and delay phases only
		st_d.pin_drive = any_src || st_d.phase inside {CRS_ACTIVE, CRS_PLL_WAIT, CRS_DELAY};
		st_d.drv_hist = {st_q.drv_hist[0], st_q.pin_drive};
		// clock out withheld until the sequence releases the core
		st_d.clkout = st_d.main_clock_control[`CRS_BIT_CLKOUT] && st_d.core_rst_n;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '0;
			st_q.main_clock_control <= `CRS_CLK_CTRL_RESET;
			st_q.rc_trim <= `CRS_TRIM_RESET;
			st_q.phase <= CRS_ACTIVE;
			st_q.pin_drive <= 1'b1;
			st_q.drv_hist <= 2'b11;
			st_q.vaddr <= 16'hfffe;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign s_axi_awready = !st_q.aw_ok;
	assign s_axi_wready  = !st_q.w_ok;
	assign s_axi_bvalid  = st_q.bvalid;
	assign s_axi_bresp   = st_q.bresp;
	assign s_axi_arready = !st_q.rvalid;
	assign s_axi_rvalid  = st_q.rvalid;
	assign s_axi_rdata   = st_q.rdata;
	assign s_axi_rresp   = st_q.rresp;
	assign reset_pin_out  = 1'b0;
	assign reset_pin_oe_n = !st_q.pin_drive;
	assign core_reset_n   = st_q.core_rst_n;
	assign vector_fetch   = st_q.fetch;
	assign vector_addr    = st_q.vaddr;
	assign cpu_clk_en     = div_en;
	assign clock_out_enable = st_q.clkout;
	assign trim_value     = st_q.rc_trim;
	// clock source is only ever read from the strap input

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence fetch_two_s;
		vector_fetch && vector_addr == 16'hfffe ##1 vector_fetch && vector_addr == 16'hffff;
	endsequence

	pin_low_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q.phase == CRS_DELAY |-> !reset_pin_oe_n)
		else $error("reset pin released during delay");
	fetch_pair_a: assert property (@(posedge aclk) disable iff (!aresetn || st_q.pin_drive)
		$rose(st_q.phase == CRS_FETCH) |=> fetch_two_s)
		else $error("vector fetch not two cycles");
	ctrl_reserved_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q.main_clock_control[7:2] == 6'h00)
		else $error("reserved control bits set");
	never_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
		reset_pin_out == 1'b0)
		else $error("reset pin driven high");
	src_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
		src.supply |=> st_q.phase == CRS_ACTIVE && st_q.cnt == 13'h0000
			&& st_q.rc_trim == 8'hff)
		else $error("source did not restart sequence");
	wdg_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		src.watchdog && !src.supply |=> st_q.watchdog_reset_flag)
		else $error("watchdog flag not set");
	wdg_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
		src.watchdog |=> !reset_pin_oe_n [*8])
		else $error("watchdog pulse too short");
	clkout_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clock_out_enable |-> st_q.main_clock_control[1] && core_reset_n)
		else $error("clock out without enable");
endmodule : crs_sequencer
`default_nettype wire

// ---- src/crs_consts.svh ----
// constants for the clock and reset sequencer: offsets, fields, resets, counts
// assumes inclusion by bare name from the modules and the testbench
`ifndef CRS_CONSTS_SVH
`define CRS_CONSTS_SVH
// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define CRS_ADDR_CLK_CTRL     4'h0
`define CRS_ADDR_TRIM         4'h4
`define CRS_ADDR_FLAGS        4'h8
`define CRS_ADDR_STATUS       4'hc
// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define CRS_BIT_SLOW          0
`define CRS_BIT_CLKOUT        1
`define CRS_BIT_SUPPLY_RESET_FLAG         2
`define CRS_BIT_WATCHDOG_RESET_FLAG         4
`define CRS_CLK_CTRL_RESET    8'h00
`define CRS_TRIM_RESET        8'hff
`define CRS_CLK_CTRL_MASK     8'h03
// ------------------------------------------------------------
// timing counts: delays in cpu cycles, the rest in aclk cycles; bus responses
// ------------------------------------------------------------
`define CRS_DELAY_SHORT       256
`define CRS_DELAY_LONG        4096
`define CRS_FETCH_CYCLES      2
`define CRS_SLOW_DIV          32
`define CRS_WDG_PULSE         16
`define CRS_PLL_STARTUP       64
`define CRS_RESP_OKAY         2'b00
`define CRS_RESP_SLVERR       2'b10
`endif

// ---- src/crs_pkg.sv ----
// types shared by the sequencer files
// uses no macros from crs_consts.svh
package crs_pkg;
	typedef enum logic [1:0] {
		CRS_OSC_RC,
		CRS_OSC_EXT,
		CRS_OSC_XTAL
	} crs_osc_t;

	typedef enum {
		CRS_ACTIVE,
		CRS_PLL_WAIT,
		CRS_DELAY,
		CRS_FETCH,
		CRS_RUN
	} crs_phase_t;

	typedef struct packed {
		logic ext_low;
		logic supply;
		logic watchdog;
		logic illegal;
	} crs_src_t;
endpackage : crs_pkg

// ---- src/crs_sync.sv ----
// two-flop synchroniser for an asynchronous level
// assumes a single clock domain on aclk
`timescale 1ns/10ps
`default_nettype none
module crs_sync (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic din,
	output var  logic dout
);
	import crs_pkg::*;
	typedef struct packed {
		logic s1;
		logic s2;
	} crs_sync_st_t;
	crs_sync_st_t st_q, st_d;

	always_comb begin
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
	end

	// idle high so reset release does not look like a pin pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= 2'b11;
		end else begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.s2;
endmodule : crs_sync
`default_nettype wire

// ---- src/crs_clkdiv.sv ----
// slow-mode divider: one-cycle enable pulse every DIV cycles, or always
// assumes aclk is the oscillator clock
`timescale 1ns/10ps
`default_nettype none
`include "crs_consts.svh"
module crs_clkdiv #(
	parameter int DIV = `CRS_SLOW_DIV
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic slow,
	output var  logic cpu_en
);
	import crs_pkg::*;
	typedef struct packed {
		logic [4:0] cnt;
		logic       en;
	} crs_div_st_t;
	crs_div_st_t st_q, st_d;

	always_comb begin
		st_d = st_q;
		if (!slow || st_q.cnt == 5'(DIV - 1)) begin
			st_d.cnt = 5'h00;
		end else begin
			st_d.cnt = st_q.cnt + 5'h01;
		end
		st_d.en = !slow || st_q.cnt == 5'(DIV - 1);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign cpu_en = st_q.en;
endmodule : crs_clkdiv
`default_nettype wire

// ---- testbench/crs_reset_partner.sv ----
// external reset circuit and the shared open-drain reset wire
// assumes the sequencer drives the pin as a level plus an active-low enable
`timescale 1ns/10ps
`default_nettype none
module crs_reset_partner #(
	parameter int PULSE_W = 6
) (
	input  wire logic aclk,
	input  wire logic pulse_go,
	input  wire logic reset_pin_out,
	input  wire logic reset_pin_oe_n,
	output wire logic pin_level
);
	logic ext_low;
	logic dev_low;
	initial ext_low = 1'b0;
	// pulse edges fall between clock edges: the pin is not clock-aligned
	always @(posedge pulse_go) begin
		#7 ext_low = 1'b1;
		repeat (PULSE_W) @(posedge aclk);
		#3 ext_low = 1'b0;
	end
	// weak pull-up wins only when nobody sinks the wire
	assign dev_low   = (reset_pin_oe_n === 1'b0) && (reset_pin_out === 1'b0);
	assign pin_level = (ext_low || dev_low) ? 1'b0 : 1'b1;
endmodule : crs_reset_partner
`default_nettype wire

// ---- testbench/test_clock_reset_sequencer.sv ----
// self-checking bench for the clock and reset sequencer
// assumes crs_pkg, crs_sequencer and crs_reset_partner are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "crs_consts.svh"
module test_clock_reset_sequencer;
	import crs_pkg::*;
	localparam int D_SHORT = 16;
	localparam int D_LONG  = 64;
	localparam int PLL_W   = 8;
	localparam int WDG_W   = 16;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, pll_enable, pin_level, pin_out;
	logic        pin_oe_n, supply, wdg, illegal, core_reset_n, vector_fetch;
	logic        cpu_clk_en, clk_out_en, pulse_go;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [15:0] vector_addr;
	logic [7:0]  trim;
	crs_osc_t    osc_select;
	int          fails, num_checks;

	crs_sequencer #(.DELAY_LONG(D_LONG), .DELAY_SHORT(D_SHORT), .PLL_STARTUP(PLL_W),
		.WDG_PULSE(WDG_W)) crs_sequencer_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.osc_select(osc_select), .pll_enable(pll_enable), .reset_pin_in(pin_level),
		.reset_pin_out(pin_out), .reset_pin_oe_n(pin_oe_n),
		.supply_monitor_reset(supply), .watchdog_underflow(wdg), .illegal_opcode(illegal),
		.core_reset_n(core_reset_n), .vector_fetch(vector_fetch),
		.vector_addr(vector_addr), .cpu_clk_en(cpu_clk_en),
		.clock_out_enable(clk_out_en), .trim_value(trim));
	crs_reset_partner crs_reset_partner_inst (.aclk(aclk), .pulse_go(pulse_go),
		.reset_pin_out(pin_out), .reset_pin_oe_n(pin_oe_n), .pin_level(pin_level));

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	// ------------------------------------------------------------
	// checking and bus tasks
	// ------------------------------------------------------------
	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check_val
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task automatic timed_out(input string what);
		fails++;
		$display("[FAIL] %s expected done seen timeout", what);
		give_verdict();
	endtask : timed_out
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
		bit aw_ok, w_ok;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'h1;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		aw_ok = 0;
		w_ok  = 0;
		for (int n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1;
				wvalid <= 1'b0;
			end
			if (bvalid === 1'b1) begin
				check_val("bresp", `CRS_RESP_OKAY, 32'(bresp));
				bready <= 1'b0;
				return;
			end
		end
		timed_out("write");
	endtask : axi_write
	task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
		bit a_ok;
		d = '0;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		a_ok = 0;
		for (int n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (!a_ok && arready === 1'b1) begin
				a_ok = 1;
				arvalid <= 1'b0;
			end
			if (rvalid === 1'b1) begin
				d = rdata;
				check_val("rresp", `CRS_RESP_OKAY, 32'(rresp));
				rready <= 1'b0;
				return;
			end
		end
		timed_out("read");
	endtask : axi_read
	// waits for the core to enter and leave reset, counting pin-low cycles
	task automatic wait_run(output int low);
		int fetch_n;
		bit seen;
		low = 0;
		fetch_n = 0;
		seen = 0;
		for (int n = 0; n < 3000; n++) begin
			@(posedge aclk);
			if (pin_oe_n === 1'b0) low++;
			if (core_reset_n === 1'b0) seen = 1;
			if (vector_fetch === 1'b1) begin
				check_val("vector_addr", (fetch_n == 0) ? 32'hfffe : 32'hffff,
					32'(vector_addr));
				fetch_n++;
			end
			if (seen && core_reset_n === 1'b1) begin
				check_val("fetch_cycles", 32'h2, 32'(fetch_n));
				return;
			end
		end
		timed_out("sequence");
	endtask : wait_run
	task automatic count_en(input int c, output int n);
		n = 0;
		repeat (c) begin
			@(posedge aclk);
			if (cpu_clk_en === 1'b1) n++;
		end
	endtask : count_en
	task automatic fire_wdg();
		wdg <= 1'b1;
		repeat (3) @(posedge aclk);
		wdg <= 1'b0;
	endtask : fire_wdg
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_sequences();
		crs_osc_t    osc[4] = '{CRS_OSC_RC, CRS_OSC_EXT, CRS_OSC_XTAL, CRS_OSC_RC};
		int          dly[4] = '{D_SHORT, D_SHORT, D_LONG, D_SHORT + PLL_W};
		int          low;
		logic [31:0] rd;
		for (int i = 0; i < 4; i++) begin
			osc_select <= osc[i];
			pll_enable <= (i == 3);
			aresetn    <= 1'b0;
			repeat (10) @(posedge aclk);
			aresetn <= 1'b1;
			wait_run(low);
			check_val("pin_low_span", 32'h1,
				32'(low >= dly[i] && low <= dly[i] + 6));
			axi_read(`CRS_ADDR_CLK_CTRL, rd);
			check_val("ctrl_reset", 32'h0, rd);
			axi_read(`CRS_ADDR_TRIM, rd);
			check_val("trim_reset", 32'hff, rd);
		end
	endtask : test_sequences
	task automatic test_control();
		logic [31:0] rd;
		int          n;
		axi_write(`CRS_ADDR_CLK_CTRL, 32'hff);
		axi_read(`CRS_ADDR_CLK_CTRL, rd);
		check_val("ctrl_reserved", 32'h3, rd);
		repeat (4) @(posedge aclk);
		check_val("clock_out_on", 32'h1, 32'(clk_out_en));
		count_en(64, n);
		check_val("slow_pulses", 32'h2, 32'(n));
		axi_write(`CRS_ADDR_CLK_CTRL, 32'h0);
		repeat (4) @(posedge aclk);
		check_val("clock_out_off", 32'h0, 32'(clk_out_en));
		count_en(64, n);
		check_val("fast_pulses", 32'd64, 32'(n));
	endtask : test_control
	task automatic test_trim_and_pin();
		logic [31:0] rd;
		int          low;
		axi_write(`CRS_ADDR_TRIM, 32'h5a);
		axi_read(`CRS_ADDR_TRIM, rd);
		check_val("trim_read", 32'h5a, rd);
		check_val("trim_port", 32'h5a, 32'(trim));
		pulse_go <= 1'b1;
		@(posedge aclk);
		pulse_go <= 1'b0;
		wait_run(low);
		check_val("pin_reset_low", 32'h1, 32'(low >= D_SHORT));
		check_val("trim_after_pin", 32'hff, 32'(trim));
		axi_write(`CRS_ADDR_TRIM, 32'h80);
		axi_read(`CRS_ADDR_TRIM, rd);
		check_val("trim_midpoint", 32'h80, rd);
	endtask : test_trim_and_pin
	task automatic test_flags();
		logic [31:0] rd;
		int          low;
		fire_wdg();
		wait_run(low);
		check_val("wdg_pin_low", 32'h1, 32'(low >= WDG_W + D_SHORT));
		supply <= 1'b1;
		repeat (4) @(posedge aclk);
		for (int i = 0; i < 30; i++) begin
			@(posedge aclk);
			check_val("supply_pin", 32'h0, 32'(pin_level));
		end
		supply <= 1'b0;
		wait_run(low);
		axi_read(`CRS_ADDR_FLAGS, rd);
		check_val("wdg_flag_by_supply", 32'h0, 32'(rd[`CRS_BIT_WATCHDOG_RESET_FLAG]));
		check_val("supply_flag", 32'h1, 32'(rd[`CRS_BIT_SUPPLY_RESET_FLAG]));
		fire_wdg();
		wait_run(low);
		axi_read(`CRS_ADDR_FLAGS, rd);
		check_val("supply_flag_read", 32'h0, 32'(rd[`CRS_BIT_SUPPLY_RESET_FLAG]));
		check_val("wdg_flag", 32'h1, 32'(rd[`CRS_BIT_WATCHDOG_RESET_FLAG]));
		axi_write(`CRS_ADDR_FLAGS, 32'h0);
		axi_read(`CRS_ADDR_FLAGS, rd);
		check_val("wdg_flag_cleared", 32'h0, 32'(rd[`CRS_BIT_WATCHDOG_RESET_FLAG]));
	endtask : test_flags
	task automatic test_illegal();
		int          low;
		logic [31:0] rd;
		illegal <= 1'b1;
		@(posedge aclk);
		illegal <= 1'b0;
		wait_run(low);
		check_val("illegal_pin_low", 32'h1, 32'(low >= D_SHORT));
		axi_read(`CRS_ADDR_STATUS, rd);
		check_val("status_run", 32'hc, rd);
	endtask : test_illegal

	always @(posedge aclk) begin
		if (pin_oe_n === 1'b0) check_val("pin_drive", 32'h0, 32'(pin_out));
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{pll_enable, supply, wdg, illegal, pulse_go} = '0;
		{awaddr, araddr, wstrb, wdata} = '0;
		osc_select = CRS_OSC_RC;
		fails = 0;
		num_checks = 0;
		test_sequences();
		test_control();
		test_trim_and_pin();
		test_flags();
		test_illegal();
		give_verdict();
	end
endmodule : test_clock_reset_sequencer
`default_nettype wire
